// ---- hdl/pfe_port_events.sv ----
// module: fatal and status event recording for one switch port
`timescale 1ns/1ps
`default_nettype none
module pfe_port_events #(
	parameter int LANES = pfe_pkg::LANES,
	parameter int ACKID_W = pfe_pkg::ACKID_W,
	parameter int FATAL_TRIES = pfe_pkg::FATAL_TRIES
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [pfe_pkg::ADDR_W-1:0] addr_in,
	input wire logic [pfe_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [pfe_pkg::DATA_W-1:0] rdata_out,
	// fabric side
	input wire logic fab_req_expired_in,
	input wire logic mcast_timeout_in,
	output logic drop_pkt_out,
	// link side
	input wire logic lresp_orphan_in,
	input wire logic lresp_timeout_in,
	input wire logic lresp_good_in,
	input wire logic dead_link_expired_in,
	input wire logic [LANES-1:0] lane_sync_expired_in,
	input wire logic inbound_unrecov_in,
	input wire logic outbound_unrecov_in,
	input wire logic peer_init_done_in,
	input wire logic cs_valid_in,
	input wire pfe_pkg::pfe_cs_kind_t cs_kind_in,
	input wire logic [ACKID_W-1:0] cs_ackid_in,
	input wire logic [(1<<ACKID_W)-1:0] ackid_busy_in,
	// notification
	output logic irq_out,
	output logic port_write_out,
	output logic port_fatal_out
);
	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (LANES < 1) begin : g_bad_lanes
		$error("pfe_port_events: at least one lane is needed");
	end
	if (ACKID_W < 1 || ACKID_W > 8) begin : g_bad_ackid
		$error("pfe_port_events: ackID width must be 1 to 8");
	end
	// both try counters use the package width, so the count must fit it
	if (FATAL_TRIES < 1 ||
		FATAL_TRIES >= (1 << pfe_pkg::CNT_W)) begin : g_bad_tries
		$error("pfe_port_events: fatal try count does not fit counter");
	end

	localparam int NEV = pfe_pkg::NUM_EV;
	localparam int CW = pfe_pkg::CNT_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NEV-1:0] sticky;
		logic [NEV-1:0] int_en;
		logic [NEV-1:0] pw_en;
		// fixed at 8 bits so the info word keeps one layout for any width
		logic [7:0] last_bad_ackid;
		logic [pfe_pkg::DATA_W-1:0] rdata;
		logic drop;
		logic irq;
		logic pw;
	} pfe_state_t;

	pfe_state_t s_r;
	pfe_state_t s_nxt;

	// ----------------------------------------------------------------
	// consecutive link-request failure counters
	// ----------------------------------------------------------------
	pfe_cnt_if #(.CW(CW)) orphan_cnt ();
	pfe_cnt_if #(.CW(CW)) timeout_cnt ();

	// a good response ends either run of failed tries
	assign orphan_cnt.hit = lresp_orphan_in;
	assign orphan_cnt.clear = lresp_good_in | lresp_timeout_in;
	assign timeout_cnt.hit = lresp_timeout_in;
	assign timeout_cnt.clear = lresp_good_in | lresp_orphan_in;

	pfe_try_counter #(
		.THRESH(FATAL_TRIES),
		.CW(CW)
	) u_orphan_cnt (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.cnt(orphan_cnt)
	);

	pfe_try_counter #(
		.THRESH(FATAL_TRIES),
		.CW(CW)
	) u_timeout_cnt (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.cnt(timeout_cnt)
	);

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	logic [5:0] fatal_src;
	logic fatal_any;
	logic sym_acks;
	logic bad_sym;
	logic [NEV-1:0] ev_set;

	always_comb begin
		fatal_src = '0;
		fatal_src[0] = orphan_cnt.fatal;
		fatal_src[1] = timeout_cnt.fatal;
		fatal_src[2] = dead_link_expired_in;
		fatal_src[3] = |lane_sync_expired_in;
		fatal_src[4] = inbound_unrecov_in;
		fatal_src[5] = outbound_unrecov_in;
		fatal_any = |fatal_src;
		// only acknowledge-type symbols name an ackID that must be busy
		sym_acks = 1'b0;
		case (cs_kind_in)
			pfe_pkg::PFE_CS_ACCEPT: begin
				sym_acks = 1'b1;
			end
			pfe_pkg::PFE_CS_NOT_ACCEPT: begin
				sym_acks = 1'b1;
			end
			pfe_pkg::PFE_CS_RETRY: begin
				sym_acks = 1'b1;
			end
			default: begin
				sym_acks = 1'b0;
			end
		endcase
		bad_sym = 1'b0;
		if (cs_valid_in && sym_acks) begin
			bad_sym = ~ackid_busy_in[cs_ackid_in];
		end
		ev_set = '0;
		ev_set[pfe_pkg::EV_FAB_ABORT] = fab_req_expired_in;
		ev_set[pfe_pkg::EV_EGR_DISCARD] = fab_req_expired_in;
		ev_set[pfe_pkg::EV_FABRIC] = fab_req_expired_in;
		ev_set[pfe_pkg::EV_GLOBAL_FAB] = fab_req_expired_in;
		ev_set[pfe_pkg::EV_MCAST_TO] = mcast_timeout_in;
		ev_set[pfe_pkg::EV_UNRECOV] = fatal_any;
		ev_set[pfe_pkg::EV_ACK_WAIT] = lresp_timeout_in;
		ev_set[pfe_pkg::EV_BAD_RESP] = lresp_orphan_in;
		ev_set[pfe_pkg::EV_PEER_READY] = peer_init_done_in;
		ev_set[pfe_pkg::EV_BAD_SYM] = bad_sym;
	end

	// ----------------------------------------------------------------
	// register access
	// ----------------------------------------------------------------
	// status registers are write-one-to-clear slices of one sticky vector;
	// both enable registers use that vector's layout, so one enable bit
	// serves the same event wherever its status bit is read
	logic [NEV-1:0] w1c;
	logic [pfe_pkg::DATA_W-1:0] rd_val;
	logic [pfe_pkg::DATA_W-1:0] info;

	always_comb begin
		info = '0;
		info[pfe_pkg::INFO_RESP_CNT_LSB +: CW] = orphan_cnt.count;
		info[pfe_pkg::INFO_TO_CNT_LSB +: CW] = timeout_cnt.count;
		info[pfe_pkg::INFO_ACKID_LSB +: 8] = s_r.last_bad_ackid;
	end

	always_comb begin
		w1c = '0;
		if (wr_in) begin
			case (addr_in)
				pfe_pkg::OFS_PORT_INT: begin
					w1c[pfe_pkg::PIS_BASE +: pfe_pkg::PIS_W] =
						wdata_in[pfe_pkg::PIS_W-1:0];
				end
				pfe_pkg::OFS_ERR_STAT: begin
					w1c[pfe_pkg::PES_BASE +: pfe_pkg::PES_W] =
						wdata_in[pfe_pkg::PES_W-1:0];
				end
				pfe_pkg::OFS_ERR_DET: begin
					w1c[pfe_pkg::PED_BASE +: pfe_pkg::PED_W] =
						wdata_in[pfe_pkg::PED_W-1:0];
				end
				pfe_pkg::OFS_FAB_INT: begin
					w1c[pfe_pkg::FIS_BASE +: pfe_pkg::FIS_W] =
						wdata_in[pfe_pkg::FIS_W-1:0];
				end
				pfe_pkg::OFS_GLB_INT: begin
					w1c[pfe_pkg::GIS_BASE +: pfe_pkg::GIS_W] =
						wdata_in[pfe_pkg::GIS_W-1:0];
				end
				default: begin
					w1c = '0;
				end
			endcase
		end
	end

	always_comb begin
		rd_val = '0;
		case (addr_in)
			pfe_pkg::OFS_PORT_INT: begin
				rd_val[pfe_pkg::PIS_W-1:0] =
					s_r.sticky[pfe_pkg::PIS_BASE +: pfe_pkg::PIS_W];
			end
			pfe_pkg::OFS_ERR_STAT: begin
				rd_val[pfe_pkg::PES_W-1:0] =
					s_r.sticky[pfe_pkg::PES_BASE +: pfe_pkg::PES_W];
			end
			pfe_pkg::OFS_ERR_DET: begin
				rd_val[pfe_pkg::PED_W-1:0] =
					s_r.sticky[pfe_pkg::PED_BASE +: pfe_pkg::PED_W];
			end
			pfe_pkg::OFS_FAB_INT: begin
				rd_val[pfe_pkg::FIS_W-1:0] =
					s_r.sticky[pfe_pkg::FIS_BASE +: pfe_pkg::FIS_W];
			end
			pfe_pkg::OFS_GLB_INT: begin
				rd_val[pfe_pkg::GIS_W-1:0] =
					s_r.sticky[pfe_pkg::GIS_BASE +: pfe_pkg::GIS_W];
			end
			pfe_pkg::OFS_INT_EN: begin
				rd_val[NEV-1:0] = s_r.int_en;
			end
			pfe_pkg::OFS_PW_EN: begin
				rd_val[NEV-1:0] = s_r.pw_en;
			end
			pfe_pkg::OFS_INFO: begin
				rd_val = info;
			end
			default: begin
				rd_val = '0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// a set in the same cycle as its clear wins, so no event is lost
		s_nxt.sticky = (s_r.sticky & ~w1c) | ev_set;
		if (wr_in && addr_in == pfe_pkg::OFS_INT_EN) begin
			s_nxt.int_en = wdata_in[NEV-1:0];
		end
		if (wr_in && addr_in == pfe_pkg::OFS_PW_EN) begin
			s_nxt.pw_en = wdata_in[NEV-1:0];
		end
		if (bad_sym) begin
			s_nxt.last_bad_ackid = '0;
			s_nxt.last_bad_ackid[ACKID_W-1:0] = cs_ackid_in;
		end
		// read data stand only in the cycle after the strobe
		s_nxt.rdata = rd_in ? rd_val : '0;
		s_nxt.drop = fab_req_expired_in;
		s_nxt.irq = |(s_nxt.sticky & s_nxt.int_en);
		s_nxt.pw = |(s_nxt.sticky & s_nxt.pw_en);
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
			s_r.sticky <= pfe_pkg::STICKY_RST;
			s_r.int_en <= pfe_pkg::INT_EN_RST;
			s_r.pw_en <= pfe_pkg::PW_EN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_out = s_r.rdata;
	assign drop_pkt_out = s_r.drop;
	assign irq_out = s_r.irq;
	assign port_write_out = s_r.pw;
	assign port_fatal_out = s_r.sticky[pfe_pkg::EV_UNRECOV];
endmodule
`default_nettype wire

// ---- hdl/pfe_pkg.sv ----
// package: register map, field layout and reset values of the port event block
package pfe_pkg;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [7:0] OFS_PORT_INT = 8'h00;
	localparam logic [7:0] OFS_ERR_STAT = 8'h04;
	localparam logic [7:0] OFS_ERR_DET = 8'h08;
	localparam logic [7:0] OFS_FAB_INT = 8'h0c;
	localparam logic [7:0] OFS_GLB_INT = 8'h10;
	localparam logic [7:0] OFS_INT_EN = 8'h14;
	localparam logic [7:0] OFS_PW_EN = 8'h18;
	localparam logic [7:0] OFS_INFO = 8'h1c;

	// ----------------------------------------------------------------
	// event bit positions in the common sticky vector
	// ----------------------------------------------------------------
	localparam int EV_FAB_ABORT = 0;
	localparam int EV_MCAST_TO = 1;
	localparam int EV_PEER_READY = 2;
	localparam int EV_EGR_DISCARD = 3;
	localparam int EV_UNRECOV = 4;
	localparam int EV_ACK_WAIT = 5;
	localparam int EV_BAD_RESP = 6;
	localparam int EV_BAD_SYM = 7;
	localparam int EV_FABRIC = 8;
	localparam int EV_GLOBAL_FAB = 9;
	localparam int NUM_EV = 10;

	// each status register is one slice of the sticky vector
	localparam int PIS_BASE = 0;
	localparam int PIS_W = 3;
	localparam int PES_BASE = 3;
	localparam int PES_W = 2;
	localparam int PED_BASE = 5;
	localparam int PED_W = 3;
	localparam int FIS_BASE = 8;
	localparam int FIS_W = 1;
	localparam int GIS_BASE = 9;
	localparam int GIS_W = 1;

	// info register fields
	localparam int INFO_RESP_CNT_LSB = 0;
	localparam int INFO_TO_CNT_LSB = 4;
	localparam int INFO_ACKID_LSB = 8;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [NUM_EV-1:0] STICKY_RST = 10'h000;
	localparam logic [NUM_EV-1:0] INT_EN_RST = 10'h000;
	localparam logic [NUM_EV-1:0] PW_EN_RST = 10'h000;
	localparam int FATAL_TRIES = 4;
	localparam int CNT_W = 3;
	localparam int ACKID_W = 6;
	localparam int LANES = 4;

	typedef enum logic [1:0] {
		PFE_CS_ACCEPT,
		PFE_CS_NOT_ACCEPT,
		PFE_CS_RETRY,
		PFE_CS_OTHER
	} pfe_cs_kind_t;

endpackage

// ---- hdl/pfe_cnt_if.sv ----
// interface: carrier between the event block and a retry-failure counter
`timescale 1ns/1ps
`default_nettype none
interface pfe_cnt_if #(parameter int CW = 3);
	logic hit;
	logic clear;
	logic fatal;
	logic [CW-1:0] count;

	modport ctr (input hit, input clear, output fatal, output count);
	modport user (output hit, output clear, input fatal, input count);
endinterface
`default_nettype wire

// ---- hdl/pfe_try_counter.sv ----
// module: counts consecutive failed link-request tries up to a threshold
`timescale 1ns/1ps
`default_nettype none
module pfe_try_counter #(
	parameter int THRESH = pfe_pkg::FATAL_TRIES,
	parameter int CW = pfe_pkg::CNT_W
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	pfe_cnt_if.ctr cnt
);
	typedef struct packed {
		logic [CW-1:0] count;
		logic fatal;
	} pfe_ctr_state_t;

	pfe_ctr_state_t s_r;
	pfe_ctr_state_t s_nxt;

	if (THRESH < 1 || THRESH >= (1 << CW)) begin : g_bad_thresh
		$error("pfe_try_counter: threshold does not fit the counter");
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.fatal = 1'b0;
		if (cnt.hit) begin
			// the threshold try fires once and starts a fresh run
			if (s_r.count == CW'(THRESH - 1)) begin
				s_nxt.fatal = 1'b1;
				s_nxt.count = '0;
			end else begin
				s_nxt.count = s_r.count + CW'(1);
			end
		end else if (cnt.clear) begin
			s_nxt.count = '0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cnt.fatal = s_r.fatal;
	assign cnt.count = s_r.count;
endmodule
`default_nettype wire

// ---- verif/pfe_peer_model.sv ----
// partner model: link partner and fabric event source
`timescale 1ns/1ps
`default_nettype none
module pfe_peer_model (
	input wire logic clock_in,
	input wire logic [13:0] ev_in,
	input wire logic [1:0] kind_in,
	input wire logic [5:0] ackid_in,
	output logic [13:0] ev_out,
	output var pfe_pkg::pfe_cs_kind_t kind_out,
	output logic [5:0] ackid_out,
	output logic [63:0] busy_out
);
	// ----------------------------------------------------------------
	// symbol launch
	// ----------------------------------------------------------------
	// ackIDs 0 to 7 outstanding for the whole run
	assign busy_out = 64'h0000_0000_0000_00ff;
	always_ff @(posedge clock_in) begin
		ev_out <= ev_in;
		kind_out <= pfe_pkg::pfe_cs_kind_t'(kind_in);
		// an idle symbol lane inverts its last ackID every cycle
		ackid_out <= ev_in[9] ? ackid_in : ~ackid_out;
	end
endmodule
`default_nettype wire

// ---- verif/pfe_port_events_assertions.sv ----
// checker: timing properties of the port event block
`timescale 1ns/1ps
`default_nettype none
module pfe_port_events_chk #(parameter int LANES = 4) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] addr_in,
	input wire logic wr_in,
	input wire logic fab_req_expired_in,
	input wire logic lresp_orphan_in,
	input wire logic lresp_timeout_in,
	input wire logic dead_link_expired_in,
	input wire logic [LANES-1:0] lane_sync_expired_in,
	input wire logic inbound_unrecov_in,
	input wire logic outbound_unrecov_in,
	input wire logic drop_pkt_out,
	input wire logic port_fatal_out
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	sequence orphan_run;
		lresp_orphan_in [*4];
	endsequence
	sequence tmo_run;
		lresp_timeout_in [*4];
	endsequence
	drop_next_a: assert property (fab_req_expired_in |=> drop_pkt_out)
		else $error("drop pulse missing");
	drop_only_a: assert property (!fab_req_expired_in |=> !drop_pkt_out)
		else $error("drop without time-out");
	orphan_fatal_a: assert property (orphan_run |-> ##2 port_fatal_out)
		else $error("orphan run not fatal");
	tmo_fatal_a: assert property (tmo_run |-> ##2 port_fatal_out)
		else $error("time-out run not fatal");
	dead_fatal_a: assert property (dead_link_expired_in |=> port_fatal_out)
		else $error("dead link not fatal");
	lane_fatal_a: assert property ((|lane_sync_expired_in)
		|=> port_fatal_out)
		else $error("lane sync not fatal");
	dir_fatal_a: assert property (
		(inbound_unrecov_in || outbound_unrecov_in) |=> port_fatal_out)
		else $error("unrecoverable not fatal");
	fatal_hold_a: assert property (
		port_fatal_out && !(wr_in && addr_in == 8'h04) |=> port_fatal_out)
		else $error("fatal flag dropped");
endmodule
bind pfe_port_events pfe_port_events_chk #(.LANES(LANES)) u_chk (.clock_in,
	.sys_rst_in, .addr_in, .wr_in, .fab_req_expired_in, .lresp_orphan_in,
	.lresp_timeout_in, .dead_link_expired_in, .lane_sync_expired_in,
	.inbound_unrecov_in, .outbound_unrecov_in, .drop_pkt_out, .port_fatal_out);
`default_nettype wire

// ---- verif/port_fatal_event_reporting_tb_top.sv ----
// testbench: port event block register and event scenarios
`timescale 1ns/1ps
`default_nettype none
module port_fatal_event_reporting_tb_top;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [13:0] ev = 14'h0;
	logic [1:0] kind = 2'h0;
	logic [5:0] ackid = 6'h0;
	logic [31:0] rdata_out;
	logic [13:0] pev;
	pfe_pkg::pfe_cs_kind_t pkind;
	logic [5:0] pack;
	logic [63:0] pbusy;
	logic drop_pkt_out, irq_out, port_write_out, port_fatal_out;
	int fails = 0;
	int cmp_count = 0;
	logic [13:0] src [7] = '{14'h20, 14'h40, 14'h80, 14'h400, 14'h800,
		14'h1000, 14'h2000};
	initial forever #2.5 clock_in = ~clock_in;
	pfe_peer_model peer (.clock_in(clock_in), .ev_in(ev), .kind_in(kind),
		.ackid_in(ackid), .ev_out(pev), .kind_out(pkind), .ackid_out(pack),
		.busy_out(pbusy));
	pfe_port_events uut (.clock_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .fab_req_expired_in(pev[0]),
		.mcast_timeout_in(pev[1]), .drop_pkt_out, .lresp_orphan_in(pev[2]),
		.lresp_timeout_in(pev[3]), .lresp_good_in(pev[4]),
		.dead_link_expired_in(pev[5]), .lane_sync_expired_in(pev[13:10]),
		.inbound_unrecov_in(pev[6]), .outbound_unrecov_in(pev[7]),
		.peer_init_done_in(pev[8]), .cs_valid_in(pev[9]), .cs_kind_in(pkind),
		.cs_ackid_in(pack), .ackid_busy_in(pbusy), .irq_out, .port_write_out,
		.port_fatal_out);
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e);
	endtask
	// events pass the peer register, then one cycle to the status bit
	task automatic pulse(input logic [13:0] e, input int n);
		@(posedge clock_in);
		ev <= e;
		repeat (n) @(posedge clock_in);
		ev <= 14'h0;
		repeat (3) @(posedge clock_in);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clock_in);
		fails++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
		wr(8'h14, 32'h3ff);
		wr(8'h18, 32'h1);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h14, 32'h3ff);
		rd(8'h18, 32'h1);
		rd(8'h20, 32'h0);
		$display("registers done");
		// the drop pulse stands one cycle, two edges after the expiry
		@(posedge clock_in);
		ev <= 14'h1;
		@(posedge clock_in);
		ev <= 14'h0;
		@(posedge clock_in);
		#1 chk(32'(drop_pkt_out), 32'h1);
		@(posedge clock_in);
		#1 chk(32'(drop_pkt_out), 32'h0);
		rd(8'h00, 32'h1);
		rd(8'h04, 32'h1);
		rd(8'h0c, 32'h1);
		rd(8'h10, 32'h1);
		chk(32'(irq_out), 32'h1);
		chk(32'(port_write_out), 32'h1);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h1);
		for (int i = 0; i < 5; i++) wr(8'(i * 4), 32'h1);
		rd(8'h00, 32'h0);
		chk(32'(irq_out), 32'h0);
		pulse(14'h2, 1);
		pulse(14'h100, 1);
		rd(8'h00, 32'h6);
		chk(32'(irq_out), 32'h1);
		chk(32'(port_write_out), 32'h0);
		wr(8'h00, 32'h6);
		$display("fabric done");
		pulse(14'h4, 3);
		pulse(14'h10, 1);
		pulse(14'h4, 3);
		rd(8'h1c, 32'h3);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h2);
		pulse(14'h4, 1);
		rd(8'h04, 32'h2);
		chk(32'(port_fatal_out), 32'h1);
		wr(8'h04, 32'h2);
		pulse(14'h4, 4);
		rd(8'h04, 32'h2);
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h2);
		pulse(14'h8, 4);
		rd(8'h08, 32'h1);
		rd(8'h04, 32'h2);
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h1);
		foreach (src[i]) begin
			pulse(src[i], 1);
			rd(8'h04, 32'h2);
			wr(8'h04, 32'h2);
		end
		rd(8'h04, 32'h0);
		chk(32'(port_fatal_out), 32'h0);
		$display("fatal done");
		for (int k = 0; k < 5; k++) begin
			@(posedge clock_in);
			kind <= 2'(k);
			ackid <= (k < 4) ? 6'h28 : 6'h03;
			pulse(14'h200, 1);
			rd(8'h08, (k < 3) ? 32'h4 : 32'h0);
			wr(8'h08, 32'h4);
		end
		rd(8'h1c, 32'h2800);
		$display("symbols done");
		stop_test();
	end
endmodule
`default_nettype wire
